// *** lai_defs.svh ***
// register offsets, bit positions, codes and timing for the alarm irq block
// assumes the serial port decodes a 5-bit address and strobes one byte
`ifndef LAI_DEFS_SVH
`define LAI_DEFS_SVH
`define LAI_ADDR_ENABLE 5'h04
`define LAI_ADDR_LIVE   5'h05
`define LAI_ADDR_LATCH  5'h06
`define LAI_RESET_BYTE  8'h00
`define LAI_BIT_GIE     7
`define LAI_BIT_DRV     6
`define LAI_BIT_FIFO    5
`define LAI_BIT_LCV     4
`define LAI_BIT_LOOP    3
`define LAI_BIT_AIS     2
`define LAI_BIT_LOS     1
`define LAI_BIT_QRSS    0
`define LAI_MODE_OFF    2'h0
`define LAI_MODE_AUTO   2'h3
`define LAI_HOLD_SEC    5
`define LAI_CLK_HZ      100000000
`define LAI_HOLD_CYCLES (`LAI_HOLD_SEC * `LAI_CLK_HZ)
`endif

// *** lai_pkg.sv ***
// types shared by the alarm irq block
// assumes lai_defs.svh supplies the numbers
package lai_pkg;
   // live detector levels, one bit per source
   typedef struct packed {
      logic driverFault;
      logic fifoMargin;
      logic codeViolation;
      logic allOnesAlarm;
      logic signalLost;
      logic patternLock;
   } lai_status_t;

   // one decoded access from the serial register port
   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [4:0] addr;
      logic [7:0] wdata;
   } lai_reg_req_t;

   typedef enum logic [1:0] {
      LC_OFF,
      LC_MANUAL,
      LC_AUTO_UP,
      LC_AUTO_DOWN
   } lai_lc_state_t;
endpackage

// *** lai_line_alarm_irq.sv ***
// alarm status, latched irq status, irq pin and loop-code detector
// assumes detector levels, pattern hits and register strobes share clk
//
// What this block does
// - global irq enable bit D7 gates every interrupt; resets to zero
// - enable bit D6 passes or masks driver fault interrupts
// - enable bit D5 passes or masks fifo margin interrupts
// - enable bit D4 passes or masks code violation interrupts
// - enable bit D3 passes or masks loop-code interrupts
// - enable bit D2 passes or masks all-ones alarm interrupts
// - enable bit D1 passes or masks signal-lost interrupts
// - enable bit D0 passes or masks pattern-lock interrupts
// - live bit D6 shows current transmit driver fault
// - live bit D5 shows fifo pointers within three bits
// - live bit D4 shows current line code violation or zero run
// - any edge of a live flag requests an interrupt when enabled
// - mode 01 or 10 is manual detection, 11 is automatic
// - manual: flag sets after loop-up or loop-down held over five seconds
// - manual: flag holds while pattern present, drops when it stops
// - manual: each flag edge requests an interrupt when enabled
// - entering automatic mode clears flag and watches loop-up only
// - automatic: loop-up over five seconds sets flag and remote loopback
// - automatic: flag stays set for as long as loopback is active
// - automatic: loop-down over five seconds ends loopback and clears flag
// - automatic: each flag change requests an interrupt when enabled
// - latched status bit sets on any live change, clears on read
// - live bit D2 shows current all-ones detection
// - live bit D1 shows current loss of receive signal
// - live bit D0 shows current pattern lock
`timescale 1ns/1ps
`include "lai_defs.svh"

module lai_line_alarm_irq #(
   parameter int unsigned HOLD_CYCLES = `LAI_HOLD_CYCLES
) (
   // clock and reset
   input  wire logic                 clk,
   input  wire logic                 nrst,
   // decoded register port
   input  wire lai_pkg::lai_reg_req_t regReq,
   output logic [7:0]                rdData_r,
   // detector levels
   input  wire lai_pkg::lai_status_t status,
   input  wire logic                 loopUpSeen,
   input  wire logic                 loopDownSeen,
   // loop-code mode field from the control register
   input  wire logic                 loopCodeModeHi,
   input  wire logic                 loopCodeModeLo,
   // outputs to pin and datapath
   output logic                      irqN_r,
   output logic                      remoteLoopback_r
);

   logic [7:0]             irqEnable_r;
   logic [7:0]             liveNow;
   logic [7:0]             live_r;
   logic [7:0]             latch_r;
   logic [7:0]             latch_nxt;
   logic                   loopCodeFlag_r;
   lai_pkg::lai_lc_state_t lcState_r;
   logic [31:0]            holdCnt_r;
   logic [1:0]             modeNow;
   logic                   inAuto;
   logic                   watched;
   logic                   lcEntry;
   logic                   holdDone;
   logic                   autoFire;
   logic                   latchRead;

   // true once the watched pattern has run past the hold time
   function automatic logic held(input logic [31:0] cnt);
      held = (cnt == HOLD_CYCLES);
   endfunction

   // register write of the enable mask
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         irqEnable_r <= `LAI_RESET_BYTE;
      end else if (regReq.wr && regReq.addr == `LAI_ADDR_ENABLE) begin
         irqEnable_r <= regReq.wdata;
      end
   end

   // live flag byte; bit 7 reads zero
   always_comb begin
      liveNow                = `LAI_RESET_BYTE;
      liveNow[`LAI_BIT_DRV]  = status.driverFault;
      liveNow[`LAI_BIT_FIFO] = status.fifoMargin;
      liveNow[`LAI_BIT_LCV]  = status.codeViolation;
      liveNow[`LAI_BIT_LOOP] = loopCodeFlag_r;
      liveNow[`LAI_BIT_AIS]  = status.allOnesAlarm;
      liveNow[`LAI_BIT_LOS]  = status.signalLost;
      liveNow[`LAI_BIT_QRSS] = status.patternLock;
   end

   // previous live value, used to see edges
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         live_r <= `LAI_RESET_BYTE;
      end else begin
         live_r <= liveNow;
      end
   end

   // a change landing on the read cycle survives: set wins over clear
   assign latchRead = regReq.rd && regReq.addr == `LAI_ADDR_LATCH;
   always_comb begin
      latch_nxt = latchRead ? `LAI_RESET_BYTE : latch_r;
      latch_nxt = latch_nxt | (liveNow ^ live_r);
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         latch_r <= `LAI_RESET_BYTE;
      end else begin
         latch_r <= latch_nxt;
      end
   end

   // irq pin, active low; bit 7 of the mask is the global gate
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         irqN_r <= 1'b1;
      end else begin
         irqN_r <= !(irqEnable_r[`LAI_BIT_GIE] &&
                     |(latch_r[6:0] & irqEnable_r[6:0]));
      end
   end

   // read data is held until the next read
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rdData_r <= `LAI_RESET_BYTE;
      end else if (regReq.rd) begin
         case (regReq.addr)
            `LAI_ADDR_ENABLE: rdData_r <= irqEnable_r;
            `LAI_ADDR_LIVE:   rdData_r <= live_r;
            `LAI_ADDR_LATCH:  rdData_r <= latch_r;
            default:          rdData_r <= `LAI_RESET_BYTE;
         endcase
      end
   end

   // loop-code mode decode and what the detector watches
   assign modeNow = {loopCodeModeHi, loopCodeModeLo};
   assign inAuto  = (lcState_r == lai_pkg::LC_AUTO_UP) ||
                    (lcState_r == lai_pkg::LC_AUTO_DOWN);
   always_comb begin
      case (lcState_r)
         lai_pkg::LC_MANUAL:    watched = loopUpSeen || loopDownSeen;
         lai_pkg::LC_AUTO_UP:   watched = loopUpSeen;
         lai_pkg::LC_AUTO_DOWN: watched = loopDownSeen;
         default:               watched = 1'b0;
      endcase
   end
   always_comb begin
      if (modeNow == `LAI_MODE_AUTO) begin
         lcEntry = !inAuto;
      end else if (modeNow == `LAI_MODE_OFF) begin
         lcEntry = (lcState_r != lai_pkg::LC_OFF);
      end else begin
         lcEntry = (lcState_r != lai_pkg::LC_MANUAL);
      end
   end
   assign holdDone = watched && held(holdCnt_r);
   assign autoFire = inAuto && holdDone && !lcEntry;

   // persistence timer; restarts when the pattern breaks or the target changes
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         holdCnt_r <= 32'h0;
      end else if (!watched || lcEntry || autoFire) begin
         holdCnt_r <= 32'h0;
      end else if (!held(holdCnt_r)) begin
         holdCnt_r <= holdCnt_r + 32'h1; // saturates, no wrap
      end
   end

   // loop-code state, flag and remote loopback; loopback follows the flag in automatic mode only
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         lcState_r        <= lai_pkg::LC_OFF;
         loopCodeFlag_r   <= 1'b0;
         remoteLoopback_r <= 1'b0;
      end else if (modeNow == `LAI_MODE_OFF) begin
         lcState_r        <= lai_pkg::LC_OFF;
         loopCodeFlag_r   <= 1'b0;
         remoteLoopback_r <= 1'b0;
      end else if (modeNow != `LAI_MODE_AUTO) begin
         lcState_r        <= lai_pkg::LC_MANUAL;
         loopCodeFlag_r   <= !lcEntry && holdDone;
         remoteLoopback_r <= 1'b0;
      end else if (lcEntry) begin
         lcState_r        <= lai_pkg::LC_AUTO_UP;
         loopCodeFlag_r   <= 1'b0;
         remoteLoopback_r <= 1'b0;
      end else begin
         case (lcState_r)
            lai_pkg::LC_AUTO_UP: begin
               if (holdDone) begin
                  lcState_r        <= lai_pkg::LC_AUTO_DOWN;
                  loopCodeFlag_r   <= 1'b1;
                  remoteLoopback_r <= 1'b1;
               end
            end
            lai_pkg::LC_AUTO_DOWN: begin // flag and loopback hold until loop-down
               if (holdDone) begin
                  lcState_r        <= lai_pkg::LC_AUTO_UP;
                  loopCodeFlag_r   <= 1'b0;
                  remoteLoopback_r <= 1'b0;
               end
            end
            default: begin
               lcState_r <= lai_pkg::LC_AUTO_UP;
            end
         endcase
      end
   end

   // checks
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!nrst);

   // irq pin: global gate, per-source pass, and idle when nothing enabled pends
   global_gate_a: assert property (
      !irqEnable_r[`LAI_BIT_GIE] |=> irqN_r)
      else $error("irq asserted with global enable clear");
   driver_irq_a: assert property (
      irqEnable_r[`LAI_BIT_GIE] && irqEnable_r[`LAI_BIT_DRV] &&
      latch_r[`LAI_BIT_DRV] |=> !irqN_r)
      else $error("driver fault irq not raised");
   fifo_irq_a: assert property (
      irqEnable_r[`LAI_BIT_GIE] && irqEnable_r[`LAI_BIT_FIFO] &&
      latch_r[`LAI_BIT_FIFO] |=> !irqN_r)
      else $error("fifo margin irq not raised");
   lcv_mask_a: assert property (
      irqEnable_r[6:0] == 7'h10 && !latch_r[`LAI_BIT_LCV] |=> irqN_r)
      else $error("masked sources raised irq");
   loop_irq_a: assert property (
      irqEnable_r[`LAI_BIT_GIE] && irqEnable_r[`LAI_BIT_LOOP] &&
      latch_r[`LAI_BIT_LOOP] |=> !irqN_r)
      else $error("loop-code irq not raised");
   ones_irq_a: assert property (
      irqEnable_r[`LAI_BIT_GIE] && irqEnable_r[`LAI_BIT_AIS] &&
      latch_r[`LAI_BIT_AIS] |=> !irqN_r)
      else $error("all-ones alarm irq not raised");
   lost_irq_a: assert property (
      irqEnable_r[`LAI_BIT_GIE] && irqEnable_r[`LAI_BIT_LOS] &&
      latch_r[`LAI_BIT_LOS] |=> !irqN_r)
      else $error("signal-lost irq not raised");
   lock_irq_a: assert property (
      irqEnable_r[`LAI_BIT_GIE] && irqEnable_r[`LAI_BIT_QRSS] &&
      latch_r[`LAI_BIT_QRSS] |=> !irqN_r)
      else $error("pattern-lock irq not raised");
   pin_idle_a: assert property (
      (latch_r[`LAI_BIT_DRV:0] & irqEnable_r[`LAI_BIT_DRV:0]) == 7'h00 |=> irqN_r)
      else $error("irq asserted with nothing enabled pending");
   pin_low_a: assert property (
      irqEnable_r[`LAI_BIT_GIE] &&
      |(latch_r[`LAI_BIT_DRV:0] & irqEnable_r[`LAI_BIT_DRV:0]) |=> !irqN_r)
      else $error("irq not asserted for enabled pending source");

   // live byte follows the detector levels one edge later
   driver_live_a: assert property (
      status.driverFault |=> live_r[`LAI_BIT_DRV])
      else $error("driver fault not shown live");
   fifo_live_a: assert property (
      nrst |=> live_r[`LAI_BIT_FIFO] == $past(status.fifoMargin))
      else $error("fifo margin not shown live");
   lcv_live_a: assert property (
      nrst |=> live_r[`LAI_BIT_LCV] == $past(status.codeViolation))
      else $error("code violation not shown live");
   ones_live_a: assert property (
      nrst |=> live_r[`LAI_BIT_AIS] == $past(status.allOnesAlarm))
      else $error("all-ones alarm not shown live");
   lost_live_a: assert property (
      nrst |=> live_r[`LAI_BIT_LOS] == $past(status.signalLost))
      else $error("signal lost not shown live");
   lock_live_a: assert property (
      nrst |=> live_r[`LAI_BIT_QRSS] == $past(status.patternLock))
      else $error("pattern lock not shown live");

   // latched status: edges set, reads clear, set wins
   edge_latch_a: assert property (
      liveNow != live_r |=> (latch_r & ($past(liveNow) ^ $past(live_r))) ==
      ($past(liveNow) ^ $past(live_r)))
      else $error("live edge not latched");
   read_clear_a: assert property (
      latchRead && liveNow == live_r |=> latch_r == `LAI_RESET_BYTE)
      else $error("latched status not cleared by read");

   // loop-code detector, off and manual modes
   mode_decode_a: assert property (
      (modeNow == 2'h1 || modeNow == 2'h2) |=> lcState_r == lai_pkg::LC_MANUAL)
      else $error("manual mode not decoded");
   mode_off_a: assert property (
      modeNow == `LAI_MODE_OFF |=> !loopCodeFlag_r && !remoteLoopback_r)
      else $error("detection off left flag or loopback set");
   manual_set_a: assert property (
      lcState_r == lai_pkg::LC_MANUAL && !lcEntry && holdCnt_r == HOLD_CYCLES &&
      (loopUpSeen || loopDownSeen) |=> loopCodeFlag_r)
      else $error("manual flag not set after hold");
   manual_early_a: assert property (
      !loopCodeFlag_r && holdCnt_r != HOLD_CYCLES |=> !loopCodeFlag_r)
      else $error("loop flag set before hold time");
   manual_drop_a: assert property (
      lcState_r == lai_pkg::LC_MANUAL && modeNow == 2'h1 &&
      !loopUpSeen && !loopDownSeen |=> !loopCodeFlag_r)
      else $error("manual flag held without pattern");
   manual_irq_a: assert property (
      lcState_r == lai_pkg::LC_MANUAL && $changed(loopCodeFlag_r) |=> latch_r[`LAI_BIT_LOOP])
      else $error("manual flag change not latched");

   // loop-code detector, automatic mode
   auto_entry_a: assert property (
      modeNow == `LAI_MODE_AUTO && !inAuto |=>
      !loopCodeFlag_r && lcState_r == lai_pkg::LC_AUTO_UP)
      else $error("auto entry did not clear flag");
   auto_rise_a: assert property (
      lcState_r == lai_pkg::LC_AUTO_UP && holdDone && !lcEntry |=>
      loopCodeFlag_r && remoteLoopback_r)
      else $error("loop-up hold did not start loopback");
   auto_keep_a: assert property (
      lcState_r == lai_pkg::LC_AUTO_DOWN && !holdDone && !lcEntry |=>
      loopCodeFlag_r && remoteLoopback_r)
      else $error("flag or loopback dropped early");
   auto_release_a: assert property (
      lcState_r == lai_pkg::LC_AUTO_DOWN && holdDone && !lcEntry |=>
      !loopCodeFlag_r && !remoteLoopback_r)
      else $error("loop-down hold did not end loopback");
   flag_irq_a: assert property (
      $changed(loopCodeFlag_r) |=> latch_r[`LAI_BIT_LOOP])
      else $error("loop flag change not latched");

   // main scenarios
   manual_flag_c: cover property (
      lcState_r == lai_pkg::LC_MANUAL && $rose(loopCodeFlag_r));
   auto_on_c: cover property ($rose(remoteLoopback_r));
   auto_off_c: cover property ($fell(remoteLoopback_r));
   irq_pin_c: cover property ($fell(irqN_r));
   read_clear_c: cover property (latchRead && latch_r != `LAI_RESET_BYTE);

endmodule // lai_line_alarm_irq

// *** lai_host_model.sv ***
// host model: drives the decoded register port, one byte per access
// assumes read data is registered on the edge that takes the read strobe
`timescale 1ns/1ps

module lai_host_model (
   // clock
   input  wire logic              clk,
   // register port
   output lai_pkg::lai_reg_req_t  req,
   input  wire logic [7:0]        rdData
);
   initial req = '0;

   // one-cycle strobe; released fields turn over so stale values never look valid
   task automatic wr(input logic [4:0] a, input logic [7:0] d);
      @(posedge clk);
      req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(posedge clk);
      req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
   endtask

   // data is taken mid-cycle after the capturing edge, where it stands until the next read;
   // the task ends on a rising edge so that the caller drives its inputs on the edge
   task automatic rd(input logic [4:0] a, output logic [7:0] d);
      @(posedge clk);
      req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
      @(posedge clk);
      req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 8'hFF};
      @(negedge clk);
      d = rdData;
      @(posedge clk);
   endtask
endmodule // lai_host_model

// *** lai_line_alarm_irq_tb.sv ***
// testbench: register sequences against the alarm irq and loop-code block
// assumes one clock; detector levels are driven here, registers via the host model
`timescale 1ns/1ps
`include "lai_defs.svh"

module lai_line_alarm_irq_tb;
   localparam int unsigned HOLD = 4;
   logic                  clk, nrst, loopUpSeen, loopDownSeen, modeHi, modeLo;
   logic                  irqN, loopback;
   logic [7:0]            rdData, got;
   lai_pkg::lai_status_t  status;
   lai_pkg::lai_reg_req_t regReq;
   int                    fail_count = 0;
   int                    checks_done = 0;
   logic [7:0]            srcBit [6] = '{8'h40, 8'h20, 8'h10, 8'h04, 8'h02, 8'h01};

   lai_line_alarm_irq #(.HOLD_CYCLES(HOLD)) i_dut (.clk(clk), .nrst(nrst), .regReq(regReq),
      .rdData_r(rdData), .status(status), .loopUpSeen(loopUpSeen),
      .loopDownSeen(loopDownSeen), .loopCodeModeHi(modeHi), .loopCodeModeLo(modeLo),
      .irqN_r(irqN), .remoteLoopback_r(loopback));
   lai_host_model i_host (.clk(clk), .req(regReq), .rdData(rdData));

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      checks_done++;
      if (seen !== exp) begin
         fail_count++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic close_out();
      $display("checks %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask

   // read one register and compare in one go
   task automatic rdChk(input logic [4:0] a, input logic [7:0] exp);
      i_host.rd(a, got);
      check(got, exp);
   endtask

   // let n edges pass, compare the irq pin mid-cycle, then realign to the next edge
   task automatic irqChk(input int n, input logic exp);
      repeat (n) @(posedge clk);
      @(negedge clk);
      check({7'h00, irqN}, {7'h00, exp});
      @(posedge clk);
   endtask

   // bounded wait for loopback, sampled mid-cycle; running out ends the run
   task automatic waitLb(input logic exp);
      int n;
      n = 0;
      @(negedge clk);
      while (loopback !== exp && n < 3 * HOLD) begin
         @(negedge clk);
         n++;
      end
      check({7'h00, loopback}, {7'h00, exp});
      if (loopback !== exp) close_out();
      @(posedge clk);
   endtask

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // watchdog so a stuck sequence still ends in the verdict
   initial begin
      repeat (5000) @(posedge clk);
      fail_count++;
      close_out();
   end

   initial begin
      {nrst, loopUpSeen, loopDownSeen, modeHi, modeLo} = '0;
      status = '0;
      repeat (20) @(posedge clk);
      nrst <= 1'b1;
      rdChk(`LAI_ADDR_ENABLE, 8'h00);
      rdChk(`LAI_ADDR_LATCH, 8'h00);
      i_host.wr(`LAI_ADDR_LIVE, 8'hFF);
      rdChk(`LAI_ADDR_LIVE, 8'h00);
      rdChk(5'h1F, 8'h00);
      // each detector source: masked, globally masked, then fully enabled
      for (int i = 0; i < 6; i++) begin
         i_host.wr(`LAI_ADDR_ENABLE, 8'h80);
         status[5-i] <= 1'b1;
         irqChk(3, 1'b1);
         rdChk(`LAI_ADDR_LIVE, srcBit[i]);
         rdChk(`LAI_ADDR_LATCH, srcBit[i]);
         i_host.wr(`LAI_ADDR_ENABLE, srcBit[i]);
         status[5-i] <= 1'b0;
         irqChk(3, 1'b1);
         rdChk(`LAI_ADDR_LATCH, srcBit[i]);
         i_host.wr(`LAI_ADDR_ENABLE, 8'h80 | srcBit[i]);
         rdChk(`LAI_ADDR_ENABLE, 8'h80 | srcBit[i]);
         status[5-i] <= 1'b1;
         irqChk(3, 1'b0);
         rdChk(`LAI_ADDR_LATCH, srcBit[i]);
         irqChk(2, 1'b1);
         status[5-i] <= 1'b0;
         irqChk(3, 1'b0);
         rdChk(`LAI_ADDR_LATCH, srcBit[i]);
      end
      // manual detection in both manual encodings
      i_host.wr(`LAI_ADDR_ENABLE, 8'h88);
      for (int m = 1; m < 3; m++) begin
         {modeHi, modeLo} <= m[1:0];
         loopUpSeen <= 1'b1;
         repeat (HOLD - 1) @(posedge clk);
         loopUpSeen <= 1'b0;
         rdChk(`LAI_ADDR_LIVE, 8'h00);
         loopDownSeen <= 1'b1;
         repeat (HOLD + 3) @(posedge clk);
         rdChk(`LAI_ADDR_LIVE, 8'h08);
         irqChk(0, 1'b0);
         loopDownSeen <= 1'b0;
         repeat (2) @(posedge clk);
         rdChk(`LAI_ADDR_LIVE, 8'h00);
         rdChk(`LAI_ADDR_LATCH, 8'h08);
      end
      // automatic: entry clears a set manual flag
      loopUpSeen <= 1'b1;
      repeat (HOLD + 3) @(posedge clk);
      {modeHi, modeLo} <= 2'h3;
      repeat (2) @(posedge clk); // entry clears the flag, the live byte follows an edge later
      rdChk(`LAI_ADDR_LIVE, 8'h00);
      check({7'h00, loopback}, 8'h00);
      waitLb(1'b1);
      rdChk(`LAI_ADDR_LIVE, 8'h08);
      loopUpSeen <= 1'b0;
      repeat (HOLD + 4) @(posedge clk);
      rdChk(`LAI_ADDR_LIVE, 8'h08);
      rdChk(`LAI_ADDR_LATCH, 8'h08);
      loopDownSeen <= 1'b1;
      waitLb(1'b0);
      rdChk(`LAI_ADDR_LIVE, 8'h00);
      irqChk(2, 1'b0);
      rdChk(`LAI_ADDR_LATCH, 8'h08);
      close_out();
   end
endmodule // lai_line_alarm_irq_tb
